/* logic/ces_sequencer.v */
// Exposure, clean, transfer and readout sequencer with a Wishbone register port.
// Assumes synchronous inputs except the trigger pins, which are synchronised here.
// Notes on behaviour
// RQ1: Continuous-clean mode clears rows repeatedly until a trigger arrives.
// RQ2: On trigger, finish the current row, stop cleaning, start collecting.
// RQ3: Normal shutter opens after trigger for exactly the exposure time.
// RQ4: Pre-open holds shutter open while cleaning, then exposure, then closes.
// RQ5: Trigger during row shift waits until that shift completes.
// RQ6: Trigger still high after readout counts as a new trigger.
// RQ7: Internal sync takes trigger from backplane; only when timing generator fitted.
// RQ8: Frame transfer uses free-run or triggered timing; shutter setting ignored.
// RQ9: Frame transfer moves image half to storage quickly, then reads out.
// RQ10: Free-run frame transfer: after exposure, transfer starts read and exposure.
// RQ11: Triggered frame transfer reads one frame per trigger after the first.
// RQ12: Long readout sets effective exposure to readout time; here the gap still adds exposure plus compensation after readout.
// RQ13: Clean before first transfer; first readout self-started and discarded.
// RQ14: Next transfer starts 50 ns after first readout ends.
// RQ15: Trigger after read: next readout after exposure plus compensation.
// RQ16: Kinetics keeps shutter open shifting images, closes and reads at end.
// RQ17: Free-run kinetics gap is shift time per row times window rows.
// RQ18: Kinetics frame count is array rows divided by window size.
// RQ19: Single-trigger kinetics captures whole series on one trigger.
// RQ20: Multiple-trigger kinetics captures one image per trigger.
// RQ21: Readout indicator is low throughout every readout.
// RQ22: Pre-open opens the shutter as soon as ready for a trigger. Here only in continuous-clean mode, not in kinetics.
// RQ23: Readout indicator high during exposure and compensation.
// RQ24: Trigger synchronised and taken on its rising edge, held two clocks.
// RQ25: Detected trigger held pending until accepted, consumed once.
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ces_regs.vh"
module ces_sequencer #(
  parameter HAS_TIMING_GEN = 1
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Triggers
  input  wire        ext_trig_i,
  input  wire        bp_trig_i,
  // Sensor control
  output reg         shutter_o,
  output reg         readout_active_low_o,
  output reg         clean_o,
  output reg         row_shift_o,
  output reg         ft_transfer_o,
  output reg         discard_o
);
  localparam ST_IDLE    = 4'h0;
  localparam ST_CLEAN   = 4'h1;
  localparam ST_WAIT    = 4'h2;
  localparam ST_EXPOSE  = 4'h3;
  localparam ST_COMP    = 4'h4;
  localparam ST_READ    = 4'h5;
  localparam ST_FT_XFER = 4'h6;
  localparam ST_GAP     = 4'h7;
  localparam ST_KSHIFT  = 4'h8;

  reg [31:0] ctrl;
  reg [31:0] exp_cyc;
  reg [31:0] comp_cyc;
  reg [15:0] vshift_cyc;
  reg [15:0] win_rows;
  reg [15:0] array_rows;
  reg [31:0] ro_cyc;
  reg [31:0] frames_done;

  reg [3:0]  state;
  reg [31:0] cnt;
  reg [15:0] row_cnt;
  reg [15:0] kframe;
  reg        first_ro;
  reg        ft_armed;
  reg        consume;
  reg        rearm;

  wire [2:0] mode    = ctrl[`CES_CTRL_MODE_HI:`CES_CTRL_MODE_LO];
  wire       shutter_open_while_waiting = ctrl[`CES_CTRL_SHUTTER_OPEN_WHILE_WAITING];
  wire       run     = ctrl[`CES_CTRL_START];
  // RQ7 backplane trigger only with timing generator
  wire       use_bp  = ctrl[`CES_CTRL_INTSYNC] && (HAS_TIMING_GEN != 0);
  wire       trig_src = use_bp ? bp_trig_i : ext_trig_i;
  wire       trig_pend;
  wire       trig_lvl;

  ces_trig_sync u_trig (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .trig_i    (trig_src),
    .consume_i (consume),
    .rearm_i   (rearm),
    .level_o   (trig_lvl),
    .pending_o (trig_pend)
  );

  // RQ18 frames per kinetics series
  wire [15:0] kin_frames = (win_rows == 16'h0000) ? 16'h0001 : (array_rows / win_rows);

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          wmerge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // Byte merge for the 16-bit registers, upper half dropped on purpose
  function [15:0] wmerge16;
    input [15:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    reg   [31:0] full;
    begin
      full     = wmerge({16'h0000, old}, nw, sel);
      wmerge16 = full[15:0];
    end
  endfunction

  function is_kin;
    input [2:0] m;
    begin
      is_kin = (m == `CES_MODE_KIN_FREE) || (m == `CES_MODE_KIN_ONE) || (m == `CES_MODE_KIN_MULT);
    end
  endfunction

  wire wb_req = cyc_i && stb_i && !ack_o;

  // Wishbone: ack one cycle after request, dropped next cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o      <= 1'b0;
      dat_o      <= 32'h00000000;
      ctrl       <= 32'h00000000;
      exp_cyc    <= `CES_EXP_RST;
      comp_cyc   <= `CES_COMP_RST;
      vshift_cyc <= `CES_VSHIFT_RST;
      win_rows   <= `CES_WIN_RST;
      array_rows <= `CES_ROWS_RST;
      ro_cyc     <= `CES_ROCYC_RST;
    end else begin
      ack_o <= wb_req;
      // Write lands on the edge where the master samples ack
      if (cyc_i && stb_i && ack_o && we_i) begin
        case (adr_i)
          `CES_CTRL_OFF:   ctrl       <= wmerge(ctrl, dat_i, sel_i);
          `CES_EXP_OFF:    exp_cyc    <= wmerge(exp_cyc, dat_i, sel_i);
          `CES_COMP_OFF:   comp_cyc   <= wmerge(comp_cyc, dat_i, sel_i);
          `CES_VSHIFT_OFF: vshift_cyc <= wmerge16(vshift_cyc, dat_i, sel_i);
          `CES_WIN_OFF:    win_rows   <= wmerge16(win_rows, dat_i, sel_i);
          `CES_ROWS_OFF:   array_rows <= wmerge16(array_rows, dat_i, sel_i);
          `CES_ROCYC_OFF:  ro_cyc     <= wmerge(ro_cyc, dat_i, sel_i);
          default:         ctrl       <= ctrl;
        endcase
      end
      if (wb_req && !we_i) begin
        case (adr_i)
          `CES_CTRL_OFF:   dat_o <= ctrl;
          `CES_EXP_OFF:    dat_o <= exp_cyc;
          `CES_COMP_OFF:   dat_o <= comp_cyc;
          `CES_VSHIFT_OFF: dat_o <= {16'h0000, vshift_cyc};
          `CES_WIN_OFF:    dat_o <= {16'h0000, win_rows};
          `CES_ROWS_OFF:   dat_o <= {16'h0000, array_rows};
          `CES_ROCYC_OFF:  dat_o <= ro_cyc;
          `CES_STAT_OFF:   dat_o <= {11'h000, trig_pend, state, kframe};
          `CES_FRAMES_OFF: dat_o <= frames_done;
          default:         dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state                <= ST_IDLE;
      cnt                  <= 32'h00000000;
      row_cnt              <= 16'h0000;
      kframe               <= 16'h0000;
      first_ro             <= 1'b0;
      ft_armed             <= 1'b0;
      consume              <= 1'b0;
      rearm                <= 1'b0;
      frames_done          <= 32'h00000000;
      shutter_o            <= 1'b0;
      readout_active_low_o <= 1'b1;
      clean_o              <= 1'b0;
      row_shift_o          <= 1'b0;
      ft_transfer_o        <= 1'b0;
      discard_o            <= 1'b0;
    end else begin
      consume       <= 1'b0;
      rearm         <= 1'b0;
      ft_transfer_o <= 1'b0;
      row_shift_o   <= 1'b0;
      case (state)
        ST_IDLE: begin
          shutter_o            <= 1'b0;
          clean_o              <= 1'b0;
          readout_active_low_o <= 1'b1;
          kframe               <= 16'h0000;
          if (run) begin
            cnt      <= 32'h00000000;
            first_ro <= 1'b1;
            state    <= ST_CLEAN;
          end
        end
        // RQ1 repeated row cleaning
        ST_CLEAN: begin
          clean_o <= 1'b1;
          // RQ22 pre-open while ready for trigger in continuous-clean mode only; ignored in frame transfer (RQ8) and kinetics
          shutter_o <= shutter_open_while_waiting && (mode == `CES_MODE_CLEAN);
          if (!run) begin
            state <= ST_IDLE;
          end else if (cnt + 32'h1 >= {16'h0000, vshift_cyc}) begin
            // RQ5 act on trigger only at row boundary
            cnt         <= 32'h00000000;
            row_shift_o <= 1'b1;
            if (mode == `CES_MODE_FT_FREE || mode == `CES_MODE_FT_TRIG) begin
              // RQ13 first readout self-launched after cleaning
              clean_o <= 1'b0;
              state   <= ST_FT_XFER;
            end else if (mode == `CES_MODE_KIN_FREE) begin
              clean_o   <= 1'b0;
              shutter_o <= 1'b1;
              state     <= ST_EXPOSE;
            end else if (trig_pend) begin
              // RQ2 stop cleaning and collect; RQ25 consume once
              consume   <= 1'b1;
              clean_o   <= 1'b0;
              // RQ3 RQ4 shutter open for exposure
              shutter_o <= 1'b1;
              state     <= ST_EXPOSE;
            end
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        // RQ20 multiple-trigger kinetics waits per image
        ST_WAIT: begin
          if (trig_pend) begin
            consume <= 1'b1;
            cnt     <= 32'h00000000;
            state   <= ST_EXPOSE;
          end
        end
        ST_EXPOSE: begin
          // RQ23 indicator high while exposing
          readout_active_low_o <= 1'b1;
          if (cnt + 32'h1 >= exp_cyc) begin
            cnt <= 32'h00000000;
            // RQ18 last image of the series closes without a further shift
            if (is_kin(mode) && (kframe + 16'h1 < kin_frames)) begin
              state <= ST_KSHIFT;
            end else begin
              // RQ3 close after exactly the exposure
              shutter_o <= 1'b0;
              state     <= ST_COMP;
            end
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        // RQ16 shift image under mask, shutter stays open
        ST_KSHIFT: begin
          row_shift_o <= 1'b1;
          // RQ17 gap is shift time times window rows
          if (cnt + 32'h1 >= {16'h0000, vshift_cyc}) begin
            cnt <= 32'h00000000;
            if (row_cnt + 16'h1 >= win_rows) begin
              row_cnt <= 16'h0000;
              kframe  <= kframe + 16'h1;
              if (mode == `CES_MODE_KIN_MULT) begin
                state <= ST_WAIT;
              end else begin
                // RQ19 one trigger runs whole series
                state <= ST_EXPOSE;
              end
            end else begin
              row_cnt <= row_cnt + 16'h1;
            end
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        ST_COMP: begin
          // RQ23 indicator high in compensation
          readout_active_low_o <= 1'b1;
          if (cnt >= comp_cyc) begin
            cnt                  <= 32'h00000000;
            readout_active_low_o <= 1'b0;
            state                <= ST_READ;
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        // RQ9 rapid half-to-half transfer starts each read
        ST_FT_XFER: begin
          ft_transfer_o        <= 1'b1;
          readout_active_low_o <= 1'b0;
          discard_o            <= first_ro;
          cnt                  <= 32'h00000000;
          ft_armed             <= 1'b0;
          state                <= ST_READ;
        end
        ST_READ: begin
          // RQ21 indicator low throughout readout
          readout_active_low_o <= 1'b0;
          if (mode == `CES_MODE_FT_TRIG && trig_pend && !ft_armed) begin
            consume  <= 1'b1;
            ft_armed <= 1'b1;
          end
          if (cnt + 32'h1 >= ro_cyc) begin
            cnt                  <= 32'h00000000;
            readout_active_low_o <= 1'b1;
            discard_o            <= 1'b0;
            frames_done          <= frames_done + 32'h1;
            kframe               <= 16'h0000;
            // RQ6 held trigger counts again
            rearm                <= trig_lvl;
            if (mode == `CES_MODE_FT_FREE || mode == `CES_MODE_FT_TRIG)
              state <= ST_GAP;
            else if (!run)
              state <= ST_IDLE;
            else
              state <= ST_CLEAN;
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        // RQ14 RQ10 RQ11 RQ12 RQ15 timing between frame transfers
        ST_GAP: begin
          if (mode == `CES_MODE_FT_TRIG && trig_pend && !ft_armed) begin
            consume  <= 1'b1;
            ft_armed <= 1'b1;
            cnt      <= 32'h00000000;
          end else begin
            cnt <= cnt + 32'h1;
          end
          if (!run) begin
            state <= ST_IDLE;
          end else if (first_ro) begin
            // The transfer state costs one cycle before readout starts
            if (cnt + 32'h2 >= `CES_FT_GAP_CYC) begin
              first_ro <= 1'b0;
              state    <= ST_FT_XFER;
            end
          end else if (mode == `CES_MODE_FT_FREE || ft_armed) begin
            if (cnt + 32'h1 >= exp_cyc + comp_cyc)
              state <= ST_FT_XFER;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* inc/ces_regs.vh */
// Register map, field positions, reset values and timing counts for the exposure sequencer.
// Assumes a 250 MHz clk_i and a 32-bit classic Wishbone slave port.
`ifndef CES_REGS_VH
`define CES_REGS_VH

// Word byte offsets
`define CES_CTRL_OFF      8'h00
`define CES_EXP_OFF       8'h04
`define CES_COMP_OFF      8'h08
`define CES_VSHIFT_OFF    8'h0C
`define CES_WIN_OFF       8'h10
`define CES_ROWS_OFF      8'h14
`define CES_ROCYC_OFF     8'h18
`define CES_STAT_OFF      8'h1C
`define CES_FRAMES_OFF    8'h20

// CTRL fields
`define CES_CTRL_START    0
`define CES_CTRL_MODE_LO  1
`define CES_CTRL_MODE_HI  3
`define CES_CTRL_SHUTTER_OPEN_WHILE_WAITING  4
`define CES_CTRL_INTSYNC  5

// Operating modes
`define CES_MODE_CLEAN    3'h0
`define CES_MODE_FT_FREE  3'h1
`define CES_MODE_FT_TRIG  3'h2
`define CES_MODE_KIN_FREE 3'h3
`define CES_MODE_KIN_ONE  3'h4
`define CES_MODE_KIN_MULT 3'h5

// Reset values
`define CES_EXP_RST       32'h000003E8
`define CES_COMP_RST      32'h00000000
`define CES_VSHIFT_RST    16'h0064
`define CES_WIN_RST       16'h0002
`define CES_ROWS_RST      16'h0006
`define CES_ROCYC_RST     32'h00000400

// Gap before the next transfer in frame transfer, 50 ns
`define CES_FT_GAP_NS     50
`define CES_CLK_NS        4
`define CES_FT_GAP_CYC    ((`CES_FT_GAP_NS + `CES_CLK_NS - 1) / `CES_CLK_NS)

`endif

/* logic/ces_trig_sync.v */
// Trigger synchroniser with rising-edge detect and a pending latch.
// Assumes trig_i is asynchronous and held at least two clk_i periods.
`timescale 1ns/1ps
`default_nettype none
module ces_trig_sync (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Trigger
  input  wire trig_i,
  input  wire consume_i,
  input  wire rearm_i,
  // Status
  output reg  level_o,
  output reg  pending_o
);
  reg meta;
  reg sync;
  reg sync_d;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta      <= 1'b0;
      sync      <= 1'b0;
      sync_d    <= 1'b0;
      level_o   <= 1'b0;
      pending_o <= 1'b0;
    end else begin
      meta    <= trig_i;
      sync    <= meta;
      sync_d  <= sync;
      level_o <= sync;
      // RQ24 rising edge detect; RQ25 set wins over consume
      if ((sync && !sync_d) || (rearm_i && sync))
        pending_o <= 1'b1;
      else if (consume_i)
        pending_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* tb/ces_checker.sv */
// Port checker for the exposure sequencer, bound to its top module.
// Assumes one clock domain and an active-high synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ces_checker (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Sensor control
  input wire logic        shutter_o,
  input wire logic        readout_active_low_o,
  input wire logic        clean_o,
  input wire logic        ft_transfer_o,
  input wire logic        discard_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i && stb_i && !ack_o;

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  a_ack_answer: assert property (req |=> ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_cause: assert property (ack_o |-> $past(req))
    else $error("ack without a request");
  a_unmapped_zero: assert property (req && !we_i && adr_i > 8'h23 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_reset_idle: assert property ($fell(rst_i) |-> !shutter_o && readout_active_low_o && !clean_o)
    else $error("outputs not idle after reset");
  a_clean_no_read: assert property (clean_o |-> readout_active_low_o)
    else $error("cleaning during readout");
  a_discard_in_read: assert property ($rose(discard_o) |-> ##[0:1] !readout_active_low_o)
    else $error("discard outside first readout");
  a_xfer_pulse: assert property (ft_transfer_o |=> !ft_transfer_o)
    else $error("transfer strobe wider than one cycle");
endmodule
bind ces_sequencer ces_checker ces_checker_i (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .shutter_o,
  .readout_active_low_o, .clean_o, .ft_transfer_o, .discard_o
);
`default_nettype wire

/* tb/ces_trig_src.sv */
// Trigger source and timing monitor on the sequencer's far side.
// Assumes pulses are launched from the bench by hierarchical call.
`timescale 1ns/1ps
`default_nettype none
module ces_trig_src (
  // Clock
  input  wire logic clk_i,
  // Watched outputs
  input  wire logic ro_n_i,
  input  wire logic shut_i,
  input  wire logic xfer_i,
  // Triggers and measurements
  output var  logic ext_o,
  output var  logic bp_o,
  output var  int   ro_cnt_o,
  output var  int   ro_len_o,
  output var  int   sh_len_o,
  output var  int   gap_o
);
  int ro_run = 0, sh_run = 0, gap_run = 0;
  initial begin
    ext_o = 1'b0;
    bp_o = 1'b0;
    ro_cnt_o = 0;
    ro_len_o = 0;
    sh_len_o = 0;
    gap_o = 0;
  end
  // Lengths in whole clocks, latched as each phase ends
  always @(posedge clk_i) begin
    ro_run <= ro_n_i ? 0 : ro_run + 1;
    sh_run <= shut_i ? sh_run + 1 : 0;
    gap_run <= ro_n_i ? gap_run + 1 : 0;
    if (ro_n_i && ro_run != 0) begin
      ro_cnt_o <= ro_cnt_o + 1;
      ro_len_o <= ro_run;
    end
    if (!shut_i && sh_run != 0)
      sh_len_o <= sh_run;
    if (xfer_i)
      gap_o <= gap_run;
  end
  task automatic pulse(input logic bp, input int hi);
    @(posedge clk_i);
    if (bp)
      bp_o <= 1'b1;
    else
      ext_o <= 1'b1;
    repeat (hi < 2 ? 2 : hi) @(posedge clk_i);
    ext_o <= 1'b0;
    bp_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* tb/test_ccd_exposure_sequencer.sv */
// Self-checking bench for the exposure sequencer.
// Assumes the checker and trigger source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ces_regs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %0h want %0h", $time, g, e); end end
module test_ccd_exposure_sequencer;
  localparam int EXP = 20, VS = 10, RO = 40;
  logic        clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wd = 32'h0, lfsr = 32'h29, dat_o, q;
  logic [31:0] m [0:6];
  logic        ack_o, ext_t, bp_t, shutter_o, ro_n, clean_o, row_shift_o, xfer, discard_o;
  int          mismatches = 0, total_checks = 0, n, k, ro_cnt, ro_len, sh_len, gap;

  initial forever #2 clk_i = ~clk_i;

  ces_sequencer ces_sequencer_i (
    .clk_i, .rst_i, .cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd),
    .dat_o, .ack_o, .ext_trig_i(ext_t), .bp_trig_i(bp_t), .shutter_o, .readout_active_low_o(ro_n),
    .clean_o, .row_shift_o, .ft_transfer_o(xfer), .discard_o
  );
  ces_trig_src src_i (
    .clk_i, .ro_n_i(ro_n), .shut_i(shutter_o), .xfer_i(xfer), .ext_o(ext_t), .bp_o(bp_t),
    .ro_cnt_o(ro_cnt), .ro_len_o(ro_len), .sh_len_o(sh_len), .gap_o(gap)
  );

  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tally_and_finish(input logic hang);
    if (hang)
      mismatches++;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000)
      tally_and_finish(1'b1);
  endtask

  // Classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    req <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wd <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (n >= 40)
      tally_and_finish(1'b1);
    q = dat_o;
    req <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic run(input logic [31:0] c);
    wb(1'b1, `CES_CTRL_OFF, 4'hF, 32'h0);
    wb(1'b1, `CES_CTRL_OFF, 4'hF, c);
  endtask

  task automatic read_cycle();
    wait_for(ro_n, 1'b0);
    wait_for(ro_n, 1'b1);
    @(posedge clk_i);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    m = '{32'h0, `CES_EXP_RST, `CES_COMP_RST, 32'(`CES_VSHIFT_RST), 32'(`CES_WIN_RST),
          32'(`CES_ROWS_RST), `CES_ROCYC_RST};
    for (int i = 1; i < 7; i++) begin
      wb(1'b0, 8'(i * 4), 4'hF, 32'h0);
      `CHK(q, m[i])
      lfsr = rnd(lfsr);
      wb(1'b1, 8'(i * 4), 4'h3, lfsr);
      m[i][15:0] = lfsr[15:0];
      wb(1'b0, 8'(i * 4), 4'hF, 32'h0);
      `CHK(q, m[i])
    end
    wb(1'b0, 8'h24, 4'hF, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b1, `CES_FRAMES_OFF, 4'hF, 32'hFFFFFFFF);
    wb(1'b0, `CES_FRAMES_OFF, 4'hF, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b1, `CES_EXP_OFF, 4'hF, 32'(EXP));
    wb(1'b1, `CES_COMP_OFF, 4'hF, 32'h3);
    wb(1'b1, `CES_VSHIFT_OFF, 4'hF, 32'(VS));
    wb(1'b1, `CES_WIN_OFF, 4'hF, 32'h2);
    wb(1'b1, `CES_ROWS_OFF, 4'hF, 32'h6);
    wb(1'b1, `CES_ROCYC_OFF, 4'hF, 32'(RO));
    $display("registers done");
    run(32'h1);
    repeat (30) @(posedge clk_i);
    `CHK(clean_o, 1'b1)
    wait_for(row_shift_o, 1'b1);
    `CHK(n <= VS, 1'b1)
    fork
      src_i.pulse(1'b0, 3);
    join_none
    wait_for(shutter_o, 1'b1);
    `CHK(n <= VS + 7, 1'b1)
    `CHK(clean_o, 1'b0)
    `CHK(ro_n, 1'b1)
    read_cycle();
    `CHK(sh_len, EXP)
    `CHK(ro_len, RO)
    repeat (30) @(posedge clk_i);
    `CHK(clean_o, 1'b1)
    k = ro_cnt;
    src_i.pulse(1'b0, 120);
    read_cycle();
    `CHK(ro_cnt, k + 2)
    $display("clean done");
    run(32'h11);
    repeat (20) @(posedge clk_i);
    `CHK(shutter_o, 1'b1)
    src_i.pulse(1'b0, 3);
    wait_for(ro_n, 1'b0);
    `CHK(shutter_o, 1'b0)
    wait_for(ro_n, 1'b1);
    repeat (5) @(posedge clk_i);
    `CHK(shutter_o, 1'b1)
    run(32'h21);
    repeat (20) @(posedge clk_i);
    src_i.pulse(1'b0, 3);
    repeat (60) @(posedge clk_i);
    `CHK(ro_n, 1'b1)
    src_i.pulse(1'b1, 3);
    read_cycle();
    `CHK(ro_len, RO)
    $display("shutter and sync done");
    // Pre-open set on purpose: frame transfer must ignore it
    run(32'h13);
    wait_for(ro_n, 1'b0);
    repeat (2) @(posedge clk_i);
    `CHK(discard_o, 1'b1)
    `CHK(shutter_o, 1'b0)
    wait_for(ro_n, 1'b1);
    wait_for(ro_n, 1'b0);
    repeat (2) @(posedge clk_i);
    `CHK(discard_o, 1'b0)
    wait_for(ro_n, 1'b1);
    @(posedge clk_i);
    `CHK(ro_len, RO)
    run(32'h5);
    wait_for(ro_n, 1'b0);
    src_i.pulse(1'b0, 3);
    wait_for(ro_n, 1'b1);
    wait_for(ro_n, 1'b0);
    repeat (2) @(posedge clk_i);
    `CHK(gap, `CES_FT_GAP_CYC)
    wait_for(ro_n, 1'b1);
    @(posedge clk_i);
    k = ro_cnt;
    repeat (200) @(posedge clk_i);
    `CHK(ro_cnt, k)
    fork
      src_i.pulse(1'b0, 3);
    join_none
    wait_for(ro_n, 1'b0);
    `CHK(n >= EXP + 3 && n <= EXP + 15, 1'b1)
    wait_for(ro_n, 1'b1);
    $display("frame transfer done");
    run(32'h7);
    wait_for(ro_n, 1'b0);
    repeat (2) @(posedge clk_i);
    `CHK(sh_len, 3 * EXP + 2 * VS * 2)
    wait_for(ro_n, 1'b1);
    run(32'h9);
    repeat (50) @(posedge clk_i);
    k = ro_cnt;
    src_i.pulse(1'b0, 3);
    wait_for(ro_n, 1'b0);
    repeat (2) @(posedge clk_i);
    `CHK(sh_len, 3 * EXP + 2 * VS * 2)
    repeat (200) @(posedge clk_i);
    `CHK(ro_cnt, k + 1)
    run(32'hB);
    repeat (20) @(posedge clk_i);
    k = ro_cnt;
    repeat (2) begin
      src_i.pulse(1'b0, 3);
      repeat (60) @(posedge clk_i);
    end
    `CHK(ro_n, 1'b1)
    `CHK(shutter_o, 1'b1)
    src_i.pulse(1'b0, 3);
    wait_for(ro_n, 1'b0);
    `CHK(shutter_o, 1'b0)
    wait_for(ro_n, 1'b1);
    @(posedge clk_i);
    `CHK(ro_cnt, k + 1)
    $display("kinetics done");
    tally_and_finish(1'b0);
  end
endmodule
`default_nettype wire
